// file: hw/uci_top.sv
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Bus side and serial side share MCLK, nothing crosses domains
// - New settings settle within eight cycles
// - Interrupt output high for enabled active type
// - Line errors report 0110, cleared by status read
// - Receive data report 0100, cleared by read
// - FIFO idle timeout reports 1100
// - Transmit empty reports 0010 at fourth priority
// - Enable bit 7 enables threshold mode
// - Threshold mode: interrupt at or below threshold
// - Threshold from control bits 5 to 4
// - Threshold mode: status bit 5 means full
// - FIFOs off disables threshold mode
// - Otherwise both report transmit empty
module uci_top
  import uci_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int CHAR_CYCLES = 400
) (
  input wire logic MCLK, // Bus clock
  input wire logic RESET, // Sync reset, high
  input wire uci_pkg::uci_ahb_req_s AHB_REQ, // AHB-Lite request
  input wire logic [31:0] HWDATA, // Write data
  output uci_pkg::uci_ahb_rsp_s AHB_RSP, // AHB-Lite response
  input wire logic TX_POP, // Serial engine takes a tx char
  output logic [7:0] TX_DATA, // Char at tx FIFO head
  output logic TX_VALID, // Tx FIFO holds a char and TX_DATA shows it
  output logic IRQ, // Interrupt to processor
  output logic EVT_IRQ // Masked sticky event interrupt
);
  import uci_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  function automatic logic [CW-1:0] quarter_of(input int n);
    quarter_of = CW'(n / 4);
  endfunction

  // Bus address phase capture
  logic dp_valid, dp_write;
  logic [7:0] dp_addr;
  wire logic take = AHB_REQ.hsel && AHB_REQ.htrans[1] && AHB_REQ.hready;

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      // Bus and character paths share MCLK, so nothing crosses domains
      dp_valid <= take;
      dp_write <= AHB_REQ.hwrite;
      dp_addr <= AHB_REQ.haddr[7:0];
    end
  end

  wire logic wr = dp_valid && dp_write;
  wire logic rd_ap = take && !AHB_REQ.hwrite;

  logic [7:0] irq_enable_reg, fifo_control_reg;
  logic [3:0] evt_status, evt_mask;
  logic [3:0] line_err;
  logic [7:0] rx_hold;

  // Derived modes
  wire logic fifo_on = fifo_control_reg[FC_ENABLE];
  wire logic thr_mode = irq_enable_reg[IE_THRESH] && fifo_on;

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      irq_enable_reg <= IE_RESET;
      fifo_control_reg <= FC_RESET;
      evt_mask <= EV_RESET;
    end
    else if (wr)
    begin
      if (dp_addr == OFS_IRQ_ENABLE)
        irq_enable_reg <= HWDATA[7:0];
      else if (dp_addr == OFS_FIFO_CONTROL)
        fifo_control_reg <= HWDATA[7:0];
      else if (dp_addr == OFS_EVT_MASK)
        evt_mask <= HWDATA[3:0];
    end
  end

  // Settle counter after an irq enable or FIFO control write
  logic [3:0] settle;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      settle <= 4'h0;
    else if (wr && (dp_addr == OFS_FIFO_CONTROL || dp_addr == OFS_IRQ_ENABLE))
      settle <= 4'(SETTLE_CYCLES);
    else if (settle != 4'h0)
      settle <= settle - 4'h1;
  end
  wire logic settled = (settle == 4'h0);

  // Receive side: characters pushed by register write
  logic [7:0] rx_data;
  logic rx_full_flag;
  logic [CW-1:0] rx_cnt;
  wire logic rx_push = wr && dp_addr == OFS_RX_PUSH && settled;
  wire logic rx_read = dp_valid && !dp_write && dp_addr == OFS_RX_DATA;
  wire logic rx_has = fifo_on ? (rx_cnt != '0) : rx_full_flag;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      rx_cnt <= '0;
      rx_full_flag <= 1'b0;
      rx_hold <= 8'h00;
    end
    else
    begin
      if (rx_push)
        rx_hold <= HWDATA[7:0];
      if (!fifo_on)
        rx_cnt <= '0;
      else if (rx_push && !rx_read && rx_cnt != CW'(DEPTH))
        rx_cnt <= rx_cnt + 1'b1;
      else if (rx_read && !rx_push && rx_cnt != '0)
        rx_cnt <= rx_cnt - 1'b1;
      if (rx_push)
        rx_full_flag <= 1'b1;
      else if (rx_read)
        rx_full_flag <= 1'b0;
    end
  end
  assign rx_data = rx_hold;

  function automatic logic [CW-1:0] rx_trigger(input logic [1:0] sel);
    case (sel)
      2'b00: rx_trigger = CW'(1);
      2'b01: rx_trigger = quarter_of(DEPTH);
      2'b10: rx_trigger = CW'(DEPTH / 2);
      default: rx_trigger = CW'(DEPTH - 2);
    endcase
  endfunction

  wire logic rx_avail = fifo_on
    ? (rx_cnt >= rx_trigger(fifo_control_reg[FC_RX_TRIG_LO +: 2])) : rx_full_flag;

  // Character timeout
  logic [31:0] idle_cnt;
  logic timeout;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      idle_cnt <= '0;
      timeout <= 1'b0;
    end
    else if (!fifo_on || rx_cnt == '0 || rx_push || rx_read)
    begin
      idle_cnt <= '0;
      timeout <= 1'b0;
    end
    else if (idle_cnt >= 32'(CHAR_TIMES * CHAR_CYCLES) - 32'd1)
      timeout <= 1'b1;
    else
      idle_cnt <= idle_cnt + 32'd1;
  end

  // Line errors latched, cleared by line status read
  wire logic ls_read = dp_valid && !dp_write && dp_addr == OFS_LINE_STATUS;
  wire logic err_set = wr && dp_addr == OFS_LINE_ERR;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      line_err <= 4'h0;
    else if (err_set)
      line_err <= line_err | HWDATA[3:0]; // set wins over a read
    else if (ls_read)
      line_err <= 4'h0;
  end

  // Transmit FIFO
  logic [AW-1:0] tx_wp, tx_rp;
  logic [CW-1:0] tx_cnt;
  wire logic tx_full = tx_cnt == CW'(DEPTH);
  wire logic tx_cap = fifo_on ? !tx_full : (tx_cnt == '0);
  wire logic tx_write = wr && dp_addr == OFS_TX_DATA && tx_cap && settled;
  wire logic tx_take = TX_POP && tx_cnt != '0;
  logic [7:0] mem_q;

  uci_fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_txmem (
    .clk(MCLK),
    .we(tx_write),
    .waddr(tx_wp),
    .wdata(HWDATA[7:0]),
    .raddr(tx_take ? tx_rp + 1'b1 : tx_rp),
    .rdata(mem_q)
  );

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end
    else
    begin
      if (tx_write)
        tx_wp <= tx_wp + 1'b1;
      if (tx_take)
        tx_rp <= tx_rp + 1'b1;
      if (tx_write && !tx_take)
        tx_cnt <= tx_cnt + 1'b1;
      else if (tx_take && !tx_write)
        tx_cnt <= tx_cnt - 1'b1;
    end
  end
  // Head read one cycle late after a write to an empty FIFO
  logic tx_fresh;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      tx_fresh <= 1'b0;
    else
      // Pop and refill of the last entry also leaves the head read stale
      tx_fresh <= tx_write && (tx_cnt == '0 || (tx_cnt == CW'(1) && tx_take));
  end
  assign TX_DATA = mem_q;
  assign TX_VALID = tx_cnt != '0 && !tx_fresh;

  function automatic logic [CW-1:0] tx_thresh(input logic [1:0] sel);
    case (sel)
      2'b00: tx_thresh = '0;
      2'b01: tx_thresh = CW'(2);
      2'b10: tx_thresh = quarter_of(DEPTH);
      default: tx_thresh = CW'(DEPTH / 2);
    endcase
  endfunction

  wire logic [CW-1:0] thr_lvl = tx_thresh(fifo_control_reg[FC_TX_THR_LO +: 2]);
  wire logic tx_empty_lvl = (tx_cnt == '0);
  wire logic tx_at_thr = thr_mode ? (tx_cnt <= thr_lvl) : tx_empty_lvl;
  wire logic ls_bit5 = thr_mode ? tx_full : tx_empty_lvl;

  // Transmit-empty source: raised on entering condition, cleared by ident read
  logic tx_src, tx_at_thr_q, ie_tx_q;
  logic [3:0] ident;
  wire logic id_read = rd_ap && AHB_REQ.haddr[7:0] == OFS_IRQ_IDENT;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      tx_src <= 1'b0;
      tx_at_thr_q <= 1'b0;
      ie_tx_q <= 1'b0;
    end
    else
    begin
      tx_at_thr_q <= tx_at_thr;
      ie_tx_q <= irq_enable_reg[IE_TX_EMPTY];
      if (!tx_at_thr)
        tx_src <= 1'b0;
      else if ((tx_at_thr && !tx_at_thr_q) || (irq_enable_reg[IE_TX_EMPTY] && !tx_src
               && !ie_tx_q))
        tx_src <= 1'b1;
      else if (id_read && ident == ID_TX)
        tx_src <= 1'b0;
    end
  end

  wire logic s_line = irq_enable_reg[IE_LINE] && line_err != 4'h0;
  wire logic s_rx = irq_enable_reg[IE_RX_DATA] && rx_avail;
  wire logic s_to = irq_enable_reg[IE_RX_DATA] && timeout;
  wire logic s_tx = irq_enable_reg[IE_TX_EMPTY] && tx_src;

  always_comb
  begin
    if (s_line)
      ident = ID_LINE;
    else if (s_rx)
      ident = ID_RX;
    else if (s_to)
      ident = ID_TIMEOUT;
    else if (s_tx)
      ident = ID_TX;
    else
      ident = ID_NONE;
  end
  assign IRQ = ident != ID_NONE;

  // Sticky events, write one to clear, set wins
  wire logic [3:0] ev_in = {s_tx, s_to, s_rx, s_line};
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      evt_status <= EV_RESET;
    else if (wr && dp_addr == OFS_EVT_STATUS)
      evt_status <= (evt_status & ~HWDATA[3:0]) | ev_in;
    else
      evt_status <= evt_status | ev_in;
  end
  assign EVT_IRQ = |(evt_status & evt_mask);

  // Read data, registered at the address phase
  wire logic [7:0] line_status_reg = {1'b0, tx_empty_lvl, ls_bit5, line_err, rx_has};
  logic [31:0] rdata_q;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      rdata_q <= 32'h0;
    else if (rd_ap)
    begin
      if (AHB_REQ.haddr[7:0] == OFS_RX_DATA)
        rdata_q <= {24'h0, rx_data};
      else if (AHB_REQ.haddr[7:0] == OFS_IRQ_ENABLE)
        rdata_q <= {24'h0, irq_enable_reg};
      else if (AHB_REQ.haddr[7:0] == OFS_IRQ_IDENT)
        rdata_q <= {24'h0, fifo_on, fifo_on, 2'b00, ident};
      else if (AHB_REQ.haddr[7:0] == OFS_FIFO_CONTROL)
        rdata_q <= {24'h0, fifo_control_reg};
      else if (AHB_REQ.haddr[7:0] == OFS_LINE_STATUS)
        rdata_q <= {24'h0, line_status_reg};
      else if (AHB_REQ.haddr[7:0] == OFS_EVT_STATUS)
        rdata_q <= {28'h0, evt_status};
      else if (AHB_REQ.haddr[7:0] == OFS_EVT_MASK)
        rdata_q <= {28'h0, evt_mask};
      else
        rdata_q <= 32'h0;
    end
  end
  // One driver for the whole response; zero wait states, always OKAY
  assign AHB_RSP = '{hrdata: rdata_q, hreadyout: 1'b1, hresp: 1'b0};
endmodule
`default_nettype wire

// file: pkg/uci_pkg.sv
`default_nettype none
package uci_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_RX_DATA = 8'h00;
  localparam logic [7:0] OFS_TX_DATA = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFS_IRQ_IDENT = 8'h0c;
  localparam logic [7:0] OFS_FIFO_CONTROL = 8'h10;
  localparam logic [7:0] OFS_LINE_STATUS = 8'h14;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h18;
  localparam logic [7:0] OFS_EVT_MASK = 8'h1c;
  localparam logic [7:0] OFS_RX_PUSH = 8'h20;
  localparam logic [7:0] OFS_LINE_ERR = 8'h24;

  // irq_enable_reg fields
  localparam int IE_RX_DATA = 0;
  localparam int IE_TX_EMPTY = 1;
  localparam int IE_LINE = 2;
  localparam int IE_THRESH = 7;
  // fifo_control_reg fields
  localparam int FC_ENABLE = 0;
  localparam int FC_TX_THR_LO = 4;
  localparam int FC_RX_TRIG_LO = 6;
  // line_status_reg fields
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_TX_EMPTY = 5;
  localparam int LS_TX_IDLE = 6;
  // Event status bits
  localparam int EV_LINE = 0;
  localparam int EV_RX = 1;
  localparam int EV_TIMEOUT = 2;
  localparam int EV_TX = 3;

  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [7:0] FC_RESET = 8'h00;
  localparam logic [3:0] EV_RESET = 4'h0;

  typedef enum logic [3:0] {
    ID_NONE = 4'b0001,
    ID_LINE = 4'b0110,
    ID_RX = 4'b0100,
    ID_TIMEOUT = 4'b1100,
    ID_TX = 4'b0010
  } uci_id_e;

  // Settle time after configuration: eight MCLK cycles
  localparam int SETTLE_CYCLES = 8;
  localparam int CHAR_TIMES = 4;

  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } uci_ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } uci_ahb_rsp_s;
endpackage
`default_nettype wire

// file: hw/uci_fifo_mem.sv
`timescale 1ns/1ns
`default_nettype none
module uci_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk, // Clock
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [WIDTH-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address
  output logic [WIDTH-1:0] rdata // Registered read data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// file: verif/uci_props.sv
`timescale 1ns/1ns
`default_nettype none
module uci_props (
  input wire logic MCLK, // Clock
  input wire logic RESET, // Reset
  input wire uci_pkg::uci_ahb_req_s AHB_REQ, // Request
  input wire logic [31:0] HWDATA, // Wdata
  input wire uci_pkg::uci_ahb_rsp_s AHB_RSP, // Response
  input wire logic TX_POP, // Taken
  input wire logic [7:0] TX_DATA, // Head
  input wire logic TX_VALID, // Valid
  input wire logic IRQ, // Irq
  input wire logic EVT_IRQ // Event irq
);
  import uci_pkg::*;
  logic wp;
  logic [7:0] wa;
  logic [7:0] ie;
  logic [7:0] fc;
  logic [3:0] msk;
  logic [4:0] age;
  wire logic tk = AHB_REQ.hsel & AHB_REQ.htrans[1] & AHB_REQ.hready;
  wire logic rt = tk & ~AHB_REQ.hwrite;
  wire logic [7:0] ad = AHB_REQ.haddr[7:0];
  wire logic cfg = wp && (wa == OFS_IRQ_ENABLE || wa == OFS_FIFO_CONTROL);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  // Age since a config write: new modes may lag by the settle time
  always_ff @(posedge MCLK)
    if (RESET)
    begin
      wp <= 1'b0;
      ie <= IE_RESET;
      fc <= FC_RESET;
      msk <= 4'h0;
      age <= 5'h0;
    end
    else
    begin
      wp <= tk & AHB_REQ.hwrite;
      wa <= tk ? ad : wa;
      ie <= (wp && wa == OFS_IRQ_ENABLE) ? HWDATA[7:0] : ie;
      fc <= (wp && wa == OFS_FIFO_CONTROL) ? HWDATA[7:0] : fc;
      msk <= (wp && wa == OFS_EVT_MASK) ? HWDATA[3:0] : msk;
      age <= cfg ? 5'h0 : age + {4'h0, age != 5'h1f};
    end
  a_bus_okay: assert property (AHB_RSP.hreadyout && !AHB_RSP.hresp)
    else $error("bus not ready");
  a_reset_quiet: assert property (disable iff (1'b0) RESET |=> !IRQ && !EVT_IRQ && !TX_VALID)
    else $error("outputs up after reset");
  a_rd_stands: assert property (!rt |=> $stable(AHB_RSP.hrdata))
    else $error("read data moved");
  a_ident_irq: assert property (rt && ad == OFS_IRQ_IDENT |=>
    (AHB_RSP.hrdata[3:0] == ID_NONE) == !$past(IRQ)) else $error("irq and ident differ");
  a_ident_legal: assert property (rt && ad == OFS_IRQ_IDENT |=>
    AHB_RSP.hrdata[3:0] inside {ID_NONE, ID_LINE, ID_RX, ID_TIMEOUT, ID_TX})
    else $error("reserved ident");
  a_evt_match: assert property (rt && ad == OFS_EVT_STATUS |=>
    (|(AHB_RSP.hrdata[3:0] & msk)) == $past(EVT_IRQ)) else $error("event irq wrong");
  a_irq_off: assert property (age > 5'd12 && ie[2:0] == 3'h0 |-> !IRQ)
    else $error("irq while disabled");
  a_ls_normal: assert property (rt && ad == OFS_LINE_STATUS && age > 5'd12 &&
    !(fc[0] && ie[7]) |=> AHB_RSP.hrdata[5] == !$past(TX_VALID)) else $error("empty bit wrong");
endmodule
bind uci_top uci_props chk (.MCLK(MCLK), .RESET(RESET), .AHB_REQ(AHB_REQ), .HWDATA(HWDATA),
  .AHB_RSP(AHB_RSP), .TX_POP(TX_POP), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .IRQ(IRQ),
  .EVT_IRQ(EVT_IRQ));
`default_nettype wire

// file: verif/uci_tx_sink.sv
`timescale 1ns/1ns
`default_nettype none
module uci_tx_sink (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic valid, // Offered
  input wire logic [7:0] data, // Char
  input wire logic go, // Low stalls
  output logic pop, // Taken
  output logic [7:0] last // Last taken
);
  // At most one char a bus cycle, never beyond what is offered
  assign pop = valid & go;
  always_ff @(posedge clk)
    if (rst)
      last <= 8'h00;
    else if (pop)
      last <= data;
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import uci_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hw = 1'b0;
  logic go = 1'b1;
  logic [1:0] ht = 2'b00;
  logic [31:0] ha = 32'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  uci_ahb_req_s req;
  uci_ahb_rsp_s rsp;
  logic pop;
  logic tv;
  logic irq;
  logic eirq;
  logic [7:0] td;
  logic [7:0] last;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  assign req = {ht, ha, hw, 3'b010, 1'b1, rsp.hreadyout};
  uci_top #(.DEPTH(16), .CHAR_CYCLES(4)) dut (.MCLK(mclk), .RESET(reset), .AHB_REQ(req),
    .HWDATA(wd), .AHB_RSP(rsp), .TX_POP(pop), .TX_DATA(td), .TX_VALID(tv), .IRQ(irq),
    .EVT_IRQ(eirq));
  uci_tx_sink sink (.clk(mclk), .rst(reset), .valid(tv), .data(td), .go(go), .pop(pop),
    .last(last));
  always #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Look mid-cycle, after the edge's updates, and return on a rising edge
  task automatic cb(input string n, ref logic s, input logic e);
    @(negedge mclk);
    chk(n, {31'h0, s}, {31'h0, e});
    @(posedge mclk);
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    ht <= 2'b10;
    ha <= {24'h0, a};
    hw <= w;
    do @(posedge mclk); while (rsp.hreadyout !== 1'b1);
    ht <= 2'b00;
    wd <= d;
    do @(posedge mclk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task t_tx;
    rdc("id", OFS_IRQ_IDENT, 32'h1);
    rdc("ls", OFS_LINE_STATUS, 32'h60);
    rdc("nil", 8'h3c, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h2);
    wt(10);
    cb("irq", irq, 1'b1);
    rdc("id", OFS_IRQ_IDENT, 32'h2);
    wt(2);
    cb("irq", irq, 1'b0);
    wr(OFS_TX_DATA, 32'ha5);
    wt(3);
    cb("irq", irq, 1'b1);
    go <= 1'b0;
    wr(OFS_TX_DATA, 32'h5a);
    wt(2);
    cb("irq", irq, 1'b0);
    rdc("ls", OFS_LINE_STATUS, 32'h0);
    go <= 1'b1;
    wt(3);
    chk("chr", {24'h0, last}, 32'h5a);
  endtask
  task t_rx;
    wr(OFS_IRQ_ENABLE, 32'h5);
    wt(10);
    wr(OFS_RX_PUSH, 32'h3c);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_LINE_ERR, 32'h1 << i);
      wt(2);
      rdc("id", OFS_IRQ_IDENT, 32'h6);
      rdc("ls", OFS_LINE_STATUS, 32'h61 | (32'h2 << i));
      rdc("id", OFS_IRQ_IDENT, 32'h4);
    end
    rdc("rx", OFS_RX_DATA, 32'h3c);
    rdc("id", OFS_IRQ_IDENT, 32'h1);
  endtask
  task t_thr;
    int lv[4] = '{0, 2, 4, 8};
    go <= 1'b0;
    wr(OFS_IRQ_ENABLE, 32'h82);
    for (int t = 0; t < 4; t++)
    begin
      wr(OFS_FIFO_CONTROL, 32'h1 | (t << 4));
      wt(10);
      for (int i = 0; i <= lv[t]; i++)
        wr(OFS_TX_DATA, i);
      rdc("id", OFS_IRQ_IDENT, 32'hc1);
      go <= 1'b1;
      wt(1);
      go <= 1'b0;
      wt(3);
      rdc("id", OFS_IRQ_IDENT, 32'hc2);
      go <= 1'b1;
      wt(20);
      go <= 1'b0;
    end
    xfer(1'b0, OFS_LINE_STATUS, 32'h0);
    chk("full", rd & 32'h20, 32'h0);
    for (int i = 0; i < 17; i++)
      wr(OFS_TX_DATA, 32'h40 + i);
    xfer(1'b0, OFS_LINE_STATUS, 32'h0);
    chk("full", rd & 32'h20, 32'h20);
    go <= 1'b1;
    wt(30);
    chk("chr", {24'h0, last}, 32'h4f);
    wr(OFS_FIFO_CONTROL, 32'h30);
    wt(10);
    rdc("ls", OFS_LINE_STATUS, 32'h60);
  endtask
  task t_tmo;
    wr(OFS_FIFO_CONTROL, 32'h41);
    wr(OFS_IRQ_ENABLE, 32'h1);
    wt(10);
    wr(OFS_RX_PUSH, 32'h11);
    rdc("id", OFS_IRQ_IDENT, 32'hc1);
    wt(26);
    rdc("id", OFS_IRQ_IDENT, 32'hcc);
    rdc("rx", OFS_RX_DATA, 32'h11);
    rdc("id", OFS_IRQ_IDENT, 32'hc1);
    for (int i = 0; i < 4; i++)
      wr(OFS_RX_PUSH, i);
    rdc("id", OFS_IRQ_IDENT, 32'hc4);
    for (int i = 0; i < 4; i++)
      xfer(1'b0, OFS_RX_DATA, 32'h0);
    rdc("id", OFS_IRQ_IDENT, 32'hc1);
  endtask
  task t_evt;
    wr(OFS_IRQ_ENABLE, 32'h4);
    wr(OFS_EVT_STATUS, 32'hf);
    rdc("ev", OFS_EVT_STATUS, 32'h0);
    wr(OFS_EVT_MASK, 32'h1);
    wr(OFS_LINE_ERR, 32'h4);
    wt(2);
    cb("eirq", eirq, 1'b1);
    wr(OFS_EVT_MASK, 32'h0);
    wt(2);
    cb("eirq", eirq, 1'b0);
    // This read clears the line error, else the clear below loses to the set
    rdc("ls", OFS_LINE_STATUS, 32'h68);
    wr(OFS_EVT_MASK, 32'h1);
    cb("eirq", eirq, 1'b1);
    wr(OFS_EVT_STATUS, 32'h1);
    wt(2);
    cb("eirq", eirq, 1'b0);
    wr(OFS_IRQ_ENABLE, 32'h80);
    wt(15);
    cb("irq", irq, 1'b0);
  endtask
  initial
  begin
    wt(10);
    reset <= 1'b0;
    t_tx;
    t_rx;
    t_thr;
    t_tmo;
    t_evt;
    end_sim;
  end
endmodule
`default_nettype wire
